// ---- pcrc_pkg.sv ----
// Constants shared by the programmable CRC generator and its shift engine.
// Assumes a 32-bit classic Wishbone bus with word-aligned registers.
package pcrc_pkg;

  // ---------------------------------------------------------------------
  // Register map (word index = byte address / 4)
  // ---------------------------------------------------------------------
  localparam int unsigned ADR_W        = 5;
  localparam logic [2:0]  IDX_CONTROL  = 3'h0;  // crc_control
  localparam logic [2:0]  IDX_TAPS     = 3'h1;  // crc_poly_taps
  localparam logic [2:0]  IDX_DATA     = 3'h2;  // data_port: write feeds FIFO, read gives result
  localparam logic [2:0]  IDX_SEED     = 3'h3;  // result preset, reads result too

  // ---------------------------------------------------------------------
  // crc_control field positions
  // ---------------------------------------------------------------------
  localparam int unsigned CTL_IDLE_HALT = 13;
  localparam int unsigned CTL_COUNT_LSB = 8;
  localparam int unsigned COUNT_W       = 5;
  localparam int unsigned CTL_FULL      = 7;
  localparam int unsigned CTL_EMPTY     = 6;
  localparam int unsigned CTL_RUN       = 4;
  localparam int unsigned CTL_LEN_LSB   = 0;
  localparam int unsigned LEN_W         = 4;

  // ---------------------------------------------------------------------
  // Data path sizes and reset values
  // ---------------------------------------------------------------------
  localparam int unsigned DATA_W        = 16;
  localparam int unsigned FIFO_SLOTS    = 16;
  localparam int unsigned PTR_W         = 4;
  localparam logic [3:0]  NARROW_MAX    = 4'h7;
  localparam logic [4:0]  DEPTH_SMALL   = 5'h08;
  localparam logic [4:0]  DEPTH_LARGE   = 5'h10;
  localparam logic [3:0]  PTR_MASK_SM   = 4'h7;
  localparam logic [3:0]  PTR_MASK_LG   = 4'hF;
  localparam logic [15:0] POLY_UNIT     = 16'h0001;
  localparam logic [4:0]  BITS_PER_CLK  = 5'h02;
  localparam logic [15:0] TAPS_RESET    = 16'h0000;
  localparam logic [3:0]  LEN_RESET     = 4'h0;
  localparam logic [15:0] CRC_RESET     = 16'h0000;

endpackage : pcrc_pkg

// ---- pcrc_shift_engine.sv ----
// Serial CRC shift engine, two message bits per clock, MSB first.
// Assumes the owner loads a word only while ready is high and stepEn is high.
`timescale 1ns/1ns
module pcrc_shift_engine (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Control
  input  wire logic        stepEn,
  input  wire logic        loadWord,
  input  wire logic [15:0] wordIn,
  input  wire logic [3:0]  polyLength,
  input  wire logic [15:0] polyTaps,
  input  wire logic        seedLoad,
  input  wire logic [15:0] seedValue,
  // Status and result
  output logic             ready,
  output logic [15:0]      crcValue
);

  logic [15:0] shiftData;
  logic [4:0]  bitsLeft;
  logic [15:0] widthMask;
  logic [15:0] polyVec;
  logic [15:0] crcOne;
  logic [15:0] crcTwo;
  logic [3:0]  idxA;
  logic [3:0]  idxB;

  // ---------------------------------------------------------------------
  // Width mask, one bit per power
  // ---------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < pcrc_pkg::DATA_W; gi++) begin : g_mask
      assign widthMask[gi] = (4'(gi) <= polyLength);
    end
  endgenerate

  // Constant term always fed back, top term implied by length
  assign polyVec = (polyTaps & widthMask) | pcrc_pkg::POLY_UNIT;

  // One LFSR step for one message bit
  function automatic logic [15:0] crcStep(input logic [15:0] c, input logic b,
                                          input logic [15:0] p, input logic [15:0] m,
                                          input logic [3:0] t);
    logic        fb;
    logic [15:0] n;
    fb = b ^ c[t];
    n  = {c[14:0], 1'b0};
    if (fb) begin
      n = n ^ p;
    end
    crcStep = n & m;
  endfunction : crcStep

  // Two bits per clock, highest remaining bit first
  assign idxA   = 4'(bitsLeft - 5'h01);
  assign idxB   = 4'(bitsLeft - pcrc_pkg::BITS_PER_CLK);
  assign crcOne = (bitsLeft != 5'h00)
                  ? crcStep(crcValue, shiftData[idxA], polyVec, widthMask, polyLength)
                  : crcValue;
  assign crcTwo = (bitsLeft >= pcrc_pkg::BITS_PER_CLK)
                  ? crcStep(crcOne, shiftData[idxB], polyVec, widthMask, polyLength)
                  : crcOne;
  assign ready  = (bitsLeft <= pcrc_pkg::BITS_PER_CLK);

  // ---------------------------------------------------------------------
  // Engine state
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      crcValue  <= pcrc_pkg::CRC_RESET;
      shiftData <= pcrc_pkg::CRC_RESET;
      bitsLeft  <= 5'h00;
    end else if (seedLoad) begin
      crcValue  <= seedValue & widthMask;
      bitsLeft  <= 5'h00;
    end else if (stepEn) begin
      crcValue <= crcTwo;
      if (loadWord) begin
        shiftData <= wordIn & widthMask;
        bitsLeft  <= 5'({1'b0, polyLength} + 5'h01);
      end else if (bitsLeft >= pcrc_pkg::BITS_PER_CLK) begin
        bitsLeft <= bitsLeft - pcrc_pkg::BITS_PER_CLK;
      end else begin
        bitsLeft <= 5'h00;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  shift_off_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !stepEn && !seedLoad |=> $stable(crcValue) && $stable(bitsLeft))
    else $error("engine moved while stopped");

  word_len_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    stepEn && loadWord && !seedLoad |=> bitsLeft == 5'({1'b0, $past(polyLength)} + 5'h01))
    else $error("word bit count wrong after load");

  step_pair_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    stepEn && !loadWord && !seedLoad && bitsLeft >= pcrc_pkg::BITS_PER_CLK
    |=> bitsLeft == $past(bitsLeft) - 5'h02)
    else $error("engine did not take two bits");

endmodule : pcrc_shift_engine

// ---- pcrc_top.sv ----
// Programmable CRC generator: Wishbone register file, input FIFO, drain event.
// Assumes a classic Wishbone master and power-state levels on the same clock.
`timescale 1ns/1ns
module pcrc_top (
  // Clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      sys_rst,
  // Wishbone slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [pcrc_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  // Power state
  input  wire logic                      sleepMode,
  input  wire logic                      idleMode,
  // Events
  output logic                           drainIrq
);

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  logic        idleHalt;
  logic        shiftRun;
  logic [3:0]  polyLength;
  logic [15:0] polyTaps;
  logic [7:0]  holdByte;
  logic [15:0] fifoMem [pcrc_pkg::FIFO_SLOTS];
  logic [3:0]  wrPtr;
  logic [3:0]  rdPtr;
  logic [4:0]  wordCount;

  // ---------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------
  logic        busReq;
  logic        busTake;
  logic        wrTake;
  logic [2:0]  regIdx;
  logic        ctlWr;
  logic        tapsWr;
  logic        dataWr;
  logic        seedWr;

  assign busReq  = wb_cyc_i & wb_stb_i;
  assign busTake = busReq & wb_ack_o;
  assign wrTake  = busTake & wb_we_i;
  assign regIdx  = wb_adr_i[pcrc_pkg::ADR_W-1:2];
  assign ctlWr   = wrTake && (regIdx == pcrc_pkg::IDX_CONTROL);
  assign tapsWr  = wrTake && (regIdx == pcrc_pkg::IDX_TAPS);
  assign dataWr  = wrTake && (regIdx == pcrc_pkg::IDX_DATA);
  assign seedWr  = wrTake && (regIdx == pcrc_pkg::IDX_SEED);

  // ---------------------------------------------------------------------
  // FIFO and flow decode
  // ---------------------------------------------------------------------
  logic        halted;
  logic        wideWord;
  logic [4:0]  fifoDepth;
  logic [3:0]  ptrMask;
  logic        fifoFull;
  logic        fifoEmpty;
  logic        wordDone;
  logic [15:0] wordIn;
  logic        engReady;
  logic        moveWord;
  logic        wrapWrite;
  logic        lastDrain;
  logic [15:0] crcValue;
  logic [4:0]  next_wordCount;

  // Sleep, or Idle with halt set, stops engine steps and word moves; bus writes, FIFO writes and seed loads still land
  assign halted    = sleepMode | (idleMode & idleHalt);
  assign wideWord  = (polyLength > pcrc_pkg::NARROW_MAX);
  assign fifoDepth = wideWord ? pcrc_pkg::DEPTH_SMALL : pcrc_pkg::DEPTH_LARGE;
  assign ptrMask   = wideWord ? pcrc_pkg::PTR_MASK_SM : pcrc_pkg::PTR_MASK_LG;
  assign fifoFull  = (wordCount == fifoDepth);
  assign fifoEmpty = (wordCount == 5'h00);

  // Word completes on the lane holding its top byte
  assign wordDone  = dataWr && (wideWord ? wb_sel_i[1] : wb_sel_i[0]);
  assign wordIn    = wideWord ? {wb_dat_i[15:8], (wb_sel_i[0] ? wb_dat_i[7:0] : holdByte)}
                              : {8'h00, wb_dat_i[7:0]};

  // Move a word when running, not frozen and engine about to free
  assign moveWord  = shiftRun && !halted && !fifoEmpty && engReady;
  assign wrapWrite = wordDone && fifoFull;
  assign lastDrain = moveWord && (wordCount == 5'h01) && !wordDone;

  // Count update: wrap wins, else add written, subtract moved
  always_comb begin
    next_wordCount = wordCount;
    if (wrapWrite) begin
      next_wordCount = 5'h00;
    end else if (wordDone && !moveWord) begin
      next_wordCount = wordCount + 5'h01;
    end else if (moveWord && !wordDone) begin
      next_wordCount = wordCount - 5'h01;
    end
  end

  // ---------------------------------------------------------------------
  // Shift engine
  // ---------------------------------------------------------------------
  pcrc_shift_engine u_engine (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .stepEn     (shiftRun && !halted),
    .loadWord   (moveWord),
    .wordIn     (fifoMem[rdPtr]),
    .polyLength (polyLength),
    .polyTaps   (polyTaps),
    .seedLoad   (seedWr),
    .seedValue  (wb_dat_i[15:0]),
    .ready      (engReady),
    .crcValue   (crcValue)
  );

  // ---------------------------------------------------------------------
  // Read view
  // ---------------------------------------------------------------------
  logic [31:0] ctlView;
  logic [31:0] readValue;

  // Unused control bits stay zero
  always_comb begin
    ctlView = 32'h0000_0000;
    ctlView[pcrc_pkg::CTL_IDLE_HALT] = idleHalt;
    ctlView[pcrc_pkg::CTL_COUNT_LSB +: pcrc_pkg::COUNT_W] = wordCount;
    ctlView[pcrc_pkg::CTL_FULL]  = fifoFull;
    ctlView[pcrc_pkg::CTL_EMPTY] = fifoEmpty;
    ctlView[pcrc_pkg::CTL_RUN]   = shiftRun;
    ctlView[pcrc_pkg::CTL_LEN_LSB +: pcrc_pkg::LEN_W] = polyLength;
  end

  // Register select; unmapped words read zero
  assign readValue = (regIdx == pcrc_pkg::IDX_CONTROL) ? ctlView :
                     (regIdx == pcrc_pkg::IDX_TAPS)    ? {16'h0000, polyTaps} :
                     (regIdx == pcrc_pkg::IDX_DATA)    ? {16'h0000, crcValue} :
                     (regIdx == pcrc_pkg::IDX_SEED)    ? {16'h0000, crcValue} :
                                                         32'h0000_0000;

  // ---------------------------------------------------------------------
  // Bus answer, one cycle after the request
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= busReq & !wb_ack_o;
      wb_dat_o <= (busReq && !wb_ack_o && !wb_we_i) ? readValue : 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      idleHalt   <= 1'b0;
      shiftRun   <= 1'b0;
      polyLength <= pcrc_pkg::LEN_RESET;
      polyTaps   <= pcrc_pkg::TAPS_RESET;
    end else begin
      if (ctlWr && wb_sel_i[1]) begin
        idleHalt <= wb_dat_i[pcrc_pkg::CTL_IDLE_HALT];
      end
      if (ctlWr && wb_sel_i[0]) begin
        shiftRun   <= wb_dat_i[pcrc_pkg::CTL_RUN];
        polyLength <= wb_dat_i[pcrc_pkg::CTL_LEN_LSB +: pcrc_pkg::LEN_W];
      end
      if (tapsWr && wb_sel_i[1]) begin
        polyTaps[15:8] <= wb_dat_i[15:8];
      end
      if (tapsWr && wb_sel_i[0]) begin
        polyTaps[7:0] <= {wb_dat_i[7:1], 1'b0};
      end
    end
  end

  // ---------------------------------------------------------------------
  // FIFO storage and pointers
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      holdByte  <= 8'h00;
      wrPtr     <= 4'h0;
      rdPtr     <= 4'h0;
      wordCount <= 5'h00;
    end else begin
      wordCount <= next_wordCount;
      if (dataWr && wideWord && wb_sel_i[0] && !wb_sel_i[1]) begin
        holdByte <= wb_dat_i[7:0]; // Low byte waits for its top byte
      end
      if (wrapWrite) begin
        wrPtr <= 4'h0;
        rdPtr <= 4'h0;
      end else begin
        if (wordDone) begin
          wrPtr <= (wrPtr + 4'h1) & ptrMask;
        end
        if (moveWord) begin
          rdPtr <= (rdPtr + 4'h1) & ptrMask;
        end
      end
    end
  end

  // Word slots
  always_ff @(posedge clk_sys) begin
    if (wordDone && !fifoFull) begin
      fifoMem[wrPtr] <= wordIn;
    end
  end

  // ---------------------------------------------------------------------
  // Drain event pulse; never raised while frozen, as no word moves
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      drainIrq <= 1'b0;
    end else begin
      drainIrq <= lastDrain;
    end
  end

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  count_bound_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wordCount <= fifoDepth)
    else $error("word count above depth");

  wrap_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wordDone && fifoFull |=> wordCount == 5'h00 && !drainIrq)
    else $error("write while full did not wrap quietly");

  drain_cause_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    drainIrq |-> $past(wordCount) == 5'h01 && wordCount == 5'h00)
    else $error("drain pulse without one-to-zero step");

  drain_seen_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wordCount == 5'h01 ##1 wordCount == 5'h00 && !$past(wrapWrite) |-> drainIrq)
    else $error("one-to-zero step without drain pulse");

  move_dec_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    moveWord && !wordDone |=> wordCount == $past(wordCount) - 5'h01)
    else $error("move did not decrement count");

  write_inc_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wordDone && !fifoFull && !moveWord |=> wordCount == $past(wordCount) + 5'h01)
    else $error("completed word did not count");

  halt_freeze_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    halted && !wordDone |=> $stable(wordCount) && $stable(rdPtr))
    else $error("frozen module moved data");

  stop_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !shiftRun |-> !moveWord)
    else $error("word moved while run clear");

  depth_sel_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    fifoFull |-> wordCount == (polyLength > pcrc_pkg::NARROW_MAX ? 5'h08 : 5'h10))
    else $error("full flag at wrong depth");

  tap_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wb_ack_o && !wb_we_i && regIdx == pcrc_pkg::IDX_TAPS |-> wb_dat_o[0] == 1'b0)
    else $error("tap bit zero read nonzero");

  // ---------------------------------------------------------------------
  // Read view checks
  // ---------------------------------------------------------------------
  // Control word as a read returns it, against the count it was taken from
  full_view_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    busReq && !wb_ack_o && !wb_we_i && regIdx == pcrc_pkg::IDX_CONTROL
    |=> wb_dat_o[pcrc_pkg::CTL_FULL] ==
        ($past(wordCount) == (($past(polyLength) > pcrc_pkg::NARROW_MAX) ? 5'h08 : 5'h10)))
    else $error("full bit read at wrong depth");

  empty_view_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    busReq && !wb_ack_o && !wb_we_i && regIdx == pcrc_pkg::IDX_CONTROL
    |=> wb_dat_o[pcrc_pkg::CTL_EMPTY] == ($past(wordCount) == 5'h00))
    else $error("empty bit read wrong");

  count_view_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    busReq && !wb_ack_o && !wb_we_i && regIdx == pcrc_pkg::IDX_CONTROL
    |=> wb_dat_o[pcrc_pkg::CTL_COUNT_LSB +: pcrc_pkg::COUNT_W] == $past(wordCount))
    else $error("word count read wrong");

  ctl_unused_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wb_ack_o && !wb_we_i && regIdx == pcrc_pkg::IDX_CONTROL
    |-> wb_dat_o[31:14] == 18'h00000 && wb_dat_o[5] == 1'b0)
    else $error("unused control bits read nonzero");

  // FIFO and engine motion, bus ack
  wrap_ptr_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wrapWrite |=> wrPtr == 4'h0 && rdPtr == 4'h0)
    else $error("wrap left pointers set");

  halt_move_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    halted |-> !moveWord && !lastDrain)
    else $error("frozen module moved a word");

  run_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !shiftRun && !seedWr |=> $stable(crcValue))
    else $error("result changed while run clear");

  drain_move_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    drainIrq |-> $past(moveWord) && !$past(wrapWrite))
    else $error("drain pulse without a move");

  ack_once_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

endmodule : pcrc_top

// ---- pcrc_cpu_model.sv ----
// Processor core model: classic Wishbone master, one request at a time.
// Assumes one clock; the bench calls busCycle and checks busTimeout.
`timescale 1ns/1ns
module pcrc_cpu_model (
  // Clock
  input  wire logic        clk_sys,
  // Wishbone master side
  output logic             wbCyc,
  output logic             wbStb,
  output logic             wbWe,
  output logic [4:0]       wbAdr,
  output logic [3:0]       wbSel,
  output logic [31:0]      wbDatW,
  input  wire logic [31:0] wbDatR,
  input  wire logic        wbAck,
  // Status
  output logic             busTimeout
);
  // ---------------------------------------------------------------
  // Bus cycle
  // ---------------------------------------------------------------
  // Idle bus at time zero
  initial begin
    {wbCyc, wbStb, wbWe, busTimeout} = 4'h0;
    wbAdr = 5'h00;
    wbSel = 4'h0;
    wbDatW = 32'h0000_0000;
  end

  // Hold the request until ack is sampled, then release
  task automatic busCycle(input logic we, input logic [4:0] adr, input logic [3:0] sel,
                          input logic [31:0] wdat, output logic [31:0] rdat);
    bit done;
    done = 1'b0;
    rdat = 32'hFFFF_FFFF;
    @(posedge clk_sys);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= sel;
    wbDatW <= wdat;
    for (int i = 0; i < 16 && !done; i++) begin
      @(posedge clk_sys);
      if (wbAck === 1'b1) begin
        done = 1'b1;
        rdat = wbDatR;
      end
    end
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    wbDatW <= ~wdat;  // Released data does not keep its value
    if (!done) busTimeout = 1'b1;
  endtask : busCycle
endmodule : pcrc_cpu_model

// ---- programmable_crc_generator_tb.sv ----
// Self-checking bench for the programmable CRC generator.
// Assumes pcrc_top with a one-cycle Wishbone ack and the core model above.
`timescale 1ns/1ns
module programmable_crc_generator_tb;
  // ---------------------------------------------------------------
  // Signals, clock and instances
  // ---------------------------------------------------------------
  logic        clk_sys   = 1'b0;
  logic        sys_rst   = 1'b1;
  logic        sleepMode = 1'b0;
  logic        idleMode  = 1'b0;
  logic        cyc, stb, we, ack, drainIrq, busTimeout;
  logic [4:0]  adr;
  logic [3:0]  sel;
  logic [31:0] datW, datR;
  int          mismatches = 0;
  int          checkCount = 0;
  int          irqCount   = 0;

  always #5 clk_sys = ~clk_sys;

  // Count drain events
  always @(posedge clk_sys) if (drainIrq === 1'b1) irqCount <= irqCount + 1;

  pcrc_top uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR),
    .wb_ack_o(ack), .sleepMode(sleepMode), .idleMode(idleMode), .drainIrq(drainIrq));

  pcrc_cpu_model cpu (.clk_sys(clk_sys), .wbCyc(cyc), .wbStb(stb), .wbWe(we), .wbAdr(adr),
    .wbSel(sel), .wbDatW(datW), .wbDatR(datR), .wbAck(ack), .busTimeout(busTimeout));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic final_report();
    $display("Checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report

  task automatic checkVal(input string what, input logic [31:0] expv, input logic [31:0] got);
    checkCount++;
    if (got !== expv) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, expv, got);
    end
  endtask : checkVal

  task automatic wr(input logic [4:0] a, input logic [3:0] s, input logic [15:0] d);
    logic [31:0] unused;
    cpu.busCycle(1'b1, a, s, {16'h0000, d}, unused);
    if (busTimeout !== 1'b0) begin
      checkVal("bus ack", 32'h0000_0000, {31'h00000000, busTimeout});
      final_report();
    end
  endtask : wr

  task automatic rdChk(input string what, input logic [4:0] a, input logic [31:0] expv);
    logic [31:0] got;
    cpu.busCycle(1'b0, a, 4'hF, 32'h0000_0000, got);
    if (busTimeout !== 1'b0) begin
      checkVal("bus ack", 32'h0000_0000, {31'h00000000, busTimeout});
      final_report();
    end
    checkVal(what, expv, got);
  endtask : rdChk

  // Reference LFSR, MSB first, width len+1
  function automatic logic [15:0] crcRef(input logic [15:0] crc, input logic [3:0] len,
                                         input logic [15:0] taps, input logic [15:0] d);
    logic [15:0] mask;
    logic        fb;
    mask = 16'hFFFF >> (4'hF - len);
    for (int i = 15; i >= 0; i--) begin
      if (i <= len) begin
        fb = d[i] ^ crc[len];
        crc = ((crc << 1) ^ (fb ? (taps | 16'h0001) : 16'h0000)) & mask;
      end
    end
    return crc;
  endfunction : crcRef

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic testRegs();
    rdChk("control reset", 5'h00, 32'h0040);
    rdChk("taps reset", 5'h04, 32'h0000);
    rdChk("result reset", 5'h08, 32'h0000);
    wr(5'h04, 4'h3, 16'hFFFF);
    rdChk("taps bit0", 5'h04, 32'hFFFE);
    wr(5'h04, 4'h1, 16'h0000);
    rdChk("taps lane", 5'h04, 32'hFF00);
    wr(5'h00, 4'h2, 16'hFFFF);
    rdChk("halt lane", 5'h00, 32'h2040);
    wr(5'h00, 4'h1, 16'hFFFF);
    rdChk("control bits", 5'h00, 32'h205F);
    wr(5'h00, 4'h3, 16'h0000);
    wr(5'h14, 4'hF, 16'hFFFF);
    rdChk("unmapped", 5'h14, 32'h0000);
    $display("register test done");
  endtask : testRegs

  task automatic testFull();
    int base;
    base = irqCount;
    wr(5'h00, 4'h3, 16'h0007);
    for (int i = 0; i < 16; i++) wr(5'h08, 4'h1, 16'h00A5);
    rdChk("full narrow", 5'h00, 32'h1087);
    wr(5'h08, 4'h1, 16'h00A5);
    rdChk("wrap narrow", 5'h00, 32'h0047);
    wr(5'h00, 4'h3, 16'h000F);
    wr(5'h08, 4'h1, 16'h00A5);
    rdChk("low byte only", 5'h00, 32'h004F);
    wr(5'h08, 4'h2, 16'h5A00);
    rdChk("high byte done", 5'h00, 32'h010F);
    for (int i = 0; i < 7; i++) wr(5'h08, 4'h3, 16'h1234);
    rdChk("full wide", 5'h00, 32'h088F);
    wr(5'h08, 4'h3, 16'h1234);
    rdChk("wrap wide", 5'h00, 32'h004F);
    checkVal("wrap events", base, irqCount);
    $display("fifo test done");
  endtask : testFull

  // Preload two words, run, wait for empty, read the result
  task automatic runCrc(input logic [3:0] len, input logic [15:0] taps,
                        input logic [15:0] w0, input logic [15:0] w1);
    logic [3:0]  s;
    logic [15:0] expCrc;
    int          base;
    s = (len > 4'h7) ? 4'h3 : 4'h1;
    expCrc = crcRef(crcRef(16'h0000, len, taps, w0), len, taps, w1);
    wr(5'h00, 4'h3, {12'h000, len});
    wr(5'h04, 4'h3, taps);
    wr(5'h0C, 4'h3, 16'h0000);
    wr(5'h08, s, w0);
    wr(5'h08, s, w1);
    rdChk("count loaded", 5'h00, {16'h0000, 12'h020, len});
    base = irqCount;
    wr(5'h00, 4'h3, {12'h001, len});
    for (int i = 0; i < 40 && irqCount == base; i++) @(posedge clk_sys);
    if (irqCount == base) begin
      checkVal("drain wait", base + 1, irqCount);
      final_report();
    end
    repeat (10) @(posedge clk_sys);
    checkVal("drain events", base + 1, irqCount);
    rdChk("empty after run", 5'h00, {16'h0000, 12'h005, len});
    rdChk("crc result", 5'h08, {16'h0000, expCrc});
    wr(5'h00, 4'h3, {12'h000, len});
    $display("crc test length %0d done", len);
  endtask : runCrc

  task automatic testFreeze();
    int base;
    wr(5'h00, 4'h3, 16'h0007);
    wr(5'h08, 4'h1, 16'h0011);
    wr(5'h08, 4'h1, 16'h0022);
    repeat (10) @(posedge clk_sys);
    rdChk("run off holds", 5'h00, 32'h0207);
    sleepMode <= 1'b1;
    wr(5'h00, 4'h3, 16'h0017);
    repeat (10) @(posedge clk_sys);
    rdChk("sleep holds", 5'h00, 32'h0217);
    sleepMode <= 1'b0;
    repeat (20) @(posedge clk_sys);
    rdChk("wake drains", 5'h00, 32'h0057);
    wr(5'h00, 4'h3, 16'h2007);
    wr(5'h08, 4'h1, 16'h0033);
    wr(5'h08, 4'h1, 16'h0044);
    idleMode <= 1'b1;
    wr(5'h00, 4'h3, 16'h2017);
    repeat (10) @(posedge clk_sys);
    rdChk("idle halt holds", 5'h00, 32'h2217);
    base = irqCount;
    wr(5'h00, 4'h3, 16'h0017);
    repeat (20) @(posedge clk_sys);
    rdChk("idle runs", 5'h00, 32'h0057);
    checkVal("idle event", base + 1, irqCount);
    idleMode <= 1'b0;
    wr(5'h00, 4'h3, 16'h0007);
    $display("power test done");
  endtask : testFreeze

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    testRegs();
    testFull();
    runCrc(4'hF, 16'h1020, 16'h1234, 16'h5678);
    runCrc(4'h7, 16'h0006, 16'h0031, 16'h0032);
    runCrc(4'h5, 16'h0012, 16'h00C5, 16'h00FF);
    testFreeze();
    final_report();
  end
endmodule : programmable_crc_generator_tb
